// *** rtl/eil_pkg.sv ***
// Notes on behaviour
// - Every falling edge of the active-low pin sets the latch, whatever the sensitivity mode.
// - A vector fetch of this interrupt makes an internal acknowledge that clears the latch.
// - Writing one to the acknowledge bit clears the latch; the bit reads zero and resets to zero.
// - Reset clears the latch and the sensitivity select, even with the pin held low.
// - In edge-only mode an acknowledge clears the latch at once.
// - In edge-and-level mode the latch holds until an acknowledge has happened and the pin is high, in any order.
// - A falling edge after a software acknowledge latches a new request.
// - The latched request reaches the priority logic only while the mask is zero; reset clears the mask.
// - The pending flag reads the pending state regardless of the mask.
// - Sensitivity select one means edges and low levels, zero means edges only.
// - The 8-bit register holds pending at bit 3, acknowledge at 2, mask at 1 and select at 0; bits 7 to 4 read zero.
// - A taken unmasked request loads the program counter from the two vector locations of this interrupt.
// - In break state acknowledge writes clear the latch only with break clear enable at one.
package eil_pkg;
  localparam logic [31:0] ext_int_status_control_idx  = 32'h0000_001a;
  // One register per bus word, so the byte address is four times the index
  localparam logic [31:0] ext_int_status_control_addr = {ext_int_status_control_idx[29:0], 2'h0};
  localparam int          pending_bit   = 3;
  localparam int          ack_bit       = 2;
  localparam int          mask_bit      = 1;
  localparam int          select_bit    = 0;
  localparam logic [7:0]  ctrl_reset    = 8'h00;
  localparam logic [15:0] vector_addr_hi = 16'hfffa;
  localparam logic [15:0] vector_addr_lo = 16'hfffb;
endpackage

// *** rtl/eil_pin_sync.sv ***
`timescale 1ns/10ps
module eil_pin_sync (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic pin_n,
  output logic      level_q,
  output logic      fall
);
  logic meta_q;
  logic stage_q;
  // Reset to zero so a pin held low through reset makes no false edge; the
  // brief low reading after reset is harmless as reset also clears the select
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q  <= 1'h0;
      stage_q <= 1'h0;
      level_q <= 1'h0;
    end else begin
      meta_q  <= pin_n;
      stage_q <= meta_q;
      level_q <= stage_q;
    end
  end
  assign fall = level_q & ~stage_q;
endmodule // eil_pin_sync

// *** rtl/eil_external_interrupt_latch.sv ***
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module eil_external_interrupt_latch (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        irq_pin_n,
  input  wire logic        vector_fetch,
  input  wire logic        break_state,
  input  wire logic        break_clear_enable,
  output logic             cpu_request,
  output logic [15:0]      vector_addr_hi,
  output logic [15:0]      vector_addr_lo,
  output logic             pin_level
);
  logic        sel_q;
  logic        wr_q;
  logic        latch_q;
  logic        latch_d;
  logic        ack_seen_q;
  logic        ack_seen_d;
  logic        mask_q;
  logic        select_q;
  logic [31:0] hrdata_q;
  logic        pin_q;
  logic        fall;
  logic        addr_hit;
  logic        rd_take;
  logic        wr_take;
  logic        sw_ack;
  logic        ack;
  logic        low_hold;
  logic [7:0]  read_value;

  eil_pin_sync u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_n   (irq_pin_n),
    .level_q (pin_q),
    .fall    (fall)
  );

  // Zero-wait slave, always OKAY; address phase captured for the write
  assign addr_hit  = hsel & hready & htrans[1] & (haddr == eil_pkg::ext_int_status_control_addr);
  assign rd_take   = addr_hit & ~hwrite;
  assign wr_take   = sel_q & wr_q;
  assign hreadyout = 1'h1;
  assign hresp     = 1'h0;
  assign hrdata    = hrdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_q <= 1'h0;
      wr_q  <= 1'h0;
    end else if (hready) begin
      sel_q <= addr_hit;
      wr_q  <= hwrite;
    end
  end

  // Break protects the latch from acknowledge writes unless clearing is enabled
  assign sw_ack = wr_take & hwdata[eil_pkg::ack_bit] & (~break_state | break_clear_enable);
  assign ack    = sw_ack | vector_fetch;
  // Level mode keeps the request while the pin stays low
  assign low_hold = select_q & ~pin_q;

  always_comb begin
    latch_d    = latch_q;
    ack_seen_d = ack_seen_q;
    if (ack) begin
      ack_seen_d = 1'h1;
    end
    if (ack_seen_d & ~low_hold) begin
      latch_d    = 1'h0;
      ack_seen_d = 1'h0;
    end
    if (fall) begin
      latch_d    = 1'h1;
      ack_seen_d = 1'h0;
    end
    if (low_hold & ~ack_seen_d) begin
      latch_d = 1'h1;
    end
    if (!latch_d) begin
      ack_seen_d = 1'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_q    <= 1'h0;
      ack_seen_q <= 1'h0;
    end else begin
      latch_q    <= latch_d;
      ack_seen_q <= ack_seen_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q   <= eil_pkg::ctrl_reset[eil_pkg::mask_bit];
      select_q <= eil_pkg::ctrl_reset[eil_pkg::select_bit];
    end else if (wr_take) begin
      mask_q   <= hwdata[eil_pkg::mask_bit];
      select_q <= hwdata[eil_pkg::select_bit];
    end
  end

  // Acknowledge and upper bits always read zero
  assign read_value = {4'h0, latch_q, 1'h0, mask_q, select_q};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata_q <= {24'h00_0000, read_value};
    end else begin
      hrdata_q <= 32'h0000_0000;
    end
  end

  assign cpu_request    = latch_q & ~mask_q;
  assign vector_addr_hi = eil_pkg::vector_addr_hi;
  assign vector_addr_lo = eil_pkg::vector_addr_lo;
  assign pin_level      = pin_q;
endmodule // eil_external_interrupt_latch

// *** test/eil_external_interrupt_latch_checker.sv ***
`timescale 1ns/10ps
module eil_external_interrupt_latch_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        irq_pin_n,
  input wire logic        vector_fetch,
  input wire logic        cpu_request,
  input wire logic [15:0] vector_addr_hi,
  input wire logic [15:0] vector_addr_lo,
  input wire logic        pin_level
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // A fetch while the pin is settled high must leave nothing pending
  sequence s_ack_high;
    vector_fetch && pin_level ##1 pin_level [*2];
  endsequence
  chk_ready_high: assert property (hreadyout) else $error("ready low");
  chk_resp_okay: assert property (!hresp) else $error("error response");
  chk_vector_hi: assert property (vector_addr_hi == 16'hfffa) else $error("vector hi");
  chk_vector_lo: assert property (vector_addr_lo == 16'hfffb) else $error("vector lo");
  chk_read_bits: assert property (hrdata[31:4] == 28'h0 && !hrdata[2]) else $error("stray read bits");
  chk_pin_sync: assert property ($stable(irq_pin_n) [*5] |-> pin_level == irq_pin_n) else $error("pin sync");
  chk_fetch_clear: assert property (s_ack_high |-> !cpu_request) else $error("fetch kept request");
  chk_reset_quiet: assert property ($rose(hresetn) |-> !cpu_request [*8]) else $error("request after reset");
endmodule // eil_external_interrupt_latch_checker
bind eil_external_interrupt_latch eil_external_interrupt_latch_checker i_chk (.hclk, .hresetn, .hrdata, .hreadyout,
  .hresp, .irq_pin_n, .vector_fetch, .cpu_request, .vector_addr_hi, .vector_addr_lo, .pin_level);

// *** test/eil_irq_source.sv ***
`timescale 1ns/10ps
module eil_irq_source (
  input  wire logic hclk,
  input  wire logic cpu_request,
  input  wire logic fetch_en,
  output logic      vector_fetch
);
  initial vector_fetch = 1'h0;
  // Every other cycle, so each fetch stays a single pulse
  always @(posedge hclk) vector_fetch <= fetch_en && cpu_request && !vector_fetch;
endmodule // eil_irq_source

// *** test/tb_external_interrupt_latch.sv ***
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_external_interrupt_latch;
  logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, pin_n = 1'h1, fetch_en = 1'h0;
  logic        brk = 1'h0, bce = 1'h0, hreadyout, cpu_request, vector_fetch;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  int          mismatches = 0, n_tests = 0, cyc = 0;
  always #2 hclk = ~hclk;
  always @(posedge hclk) if (++cyc == 2000) begin mismatches++; wrap_up(); end
  eil_external_interrupt_latch i_eil_external_interrupt_latch (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .irq_pin_n(pin_n), .vector_fetch,
    .break_state(brk), .break_clear_enable(bce), .cpu_request, .vector_addr_hi(), .vector_addr_lo(), .pin_level());
  eil_irq_source i_eil_irq_source (.hclk, .cpu_request, .fetch_en, .vector_fetch);
  task automatic acc(input logic [31:0] a, input logic w, input logic [7:0] d);
    @(posedge hclk);
    {hsel, htrans, haddr, hwrite} <= {1'h1, 2'h2, a, w};
    do @(posedge hclk); while (!hreadyout);
    {hsel, htrans, hwdata} <= {1'h0, 2'h0, 24'h0, d};
    do @(posedge hclk); while (!hreadyout);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] d); acc(eil_pkg::ext_int_status_control_addr, 1'h1, d); endtask
  task automatic rd(input logic [7:0] e);
    acc(eil_pkg::ext_int_status_control_addr, 1'h0, 8'h00);
    `CHK("status", {24'h0, e}, r)
  endtask
  // Eight cycles covers the synchroniser and the latch with margin
  task automatic pin(input logic v); @(posedge hclk); pin_n <= v; repeat (8) @(posedge hclk); endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    rd(8'h00);
    wr(8'h02);
    pin(1'h0);
    rd(8'h0a);
    `CHK("request", 1'h0, cpu_request)
    wr(8'h04);
    rd(8'h00);
    pin(1'h1);
    pin(1'h0);
    rd(8'h08);
    `CHK("request", 1'h1, cpu_request)
    pin(1'h1);
    fetch_en <= 1'h1;
    pin(1'h1);
    fetch_en <= 1'h0;
    rd(8'h00);
    wr(8'h01);
    pin(1'h0);
    wr(8'h05);
    rd(8'h09);
    pin(1'h1);
    rd(8'h01);
    wr(8'h00);
    brk <= 1'h1;
    pin(1'h0);
    wr(8'h04);
    rd(8'h08);
    bce <= 1'h1;
    wr(8'h04);
    brk <= 1'h0;
    rd(8'h00);
    acc(32'h1c, 1'h1, 8'h03);
    acc(32'h1c, 1'h0, 8'h00);
    `CHK("unmapped", 32'h0, r)
    rd(8'h00);
    pin(1'h1);
    wr(8'h03);
    pin(1'h0);
    pin(1'h1);
    rd(8'h0b);
    pin(1'h0);
    hresetn <= 1'h0;
    @(posedge hclk);
    hresetn <= 1'h1;
    pin(1'h0);
    rd(8'h00);
    wrap_up();
  end
endmodule // tb_external_interrupt_latch
